/* File: design/bmpc_pkg.sv */
// Constants, encodings and types shared by the burst-mode protection controller
package bmpc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int NORM_F_LO_KHZ = 100;
  localparam int NORM_F_HI_KHZ = 125;
  localparam int BURST_F_LO_KHZ = 83;
  localparam int BURST_F_HI_KHZ = 103;
  localparam int OSC_W = 8;
  localparam logic [OSC_W-1:0] NORM_LO_CYC = OSC_W'(CLK_HZ / (NORM_F_LO_KHZ * 1000));
  localparam logic [OSC_W-1:0] NORM_HI_CYC = OSC_W'(CLK_HZ / (NORM_F_HI_KHZ * 1000));
  localparam logic [OSC_W-1:0] BURST_LO_CYC = OSC_W'(CLK_HZ / (BURST_F_LO_KHZ * 1000));
  localparam logic [OSC_W-1:0] BURST_HI_CYC = OSC_W'(CLK_HZ / (BURST_F_HI_KHZ * 1000));
  localparam int BLANK_W = 16;
  localparam int ENTRY_BLANK_US = 20;
  localparam int OLP_BLANK_US = 30;
  localparam int RESTART_US = 200;
  localparam logic [BLANK_W-1:0] ENTRY_BLANK_CYC = BLANK_W'(ENTRY_BLANK_US * (CLK_HZ / 1_000_000));
  localparam logic [BLANK_W-1:0] OLP_BLANK_CYC = BLANK_W'(OLP_BLANK_US * (CLK_HZ / 1_000_000));
  localparam logic [BLANK_W-1:0] RESTART_CYC = BLANK_W'(RESTART_US * (CLK_HZ / 1_000_000));
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
  localparam int CTRL_VARIANT_BIT = 0;
  localparam logic CTRL_VARIANT_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OPT_LSB = 8;
  localparam int STAT_NONISO_BIT = 10;
  localparam int STAT_ODD_BIT = 11;
  localparam int STAT_LINE_OVERVOLTAGE_GUARD_BIT = 12;
  localparam logic [1:0] OPT_NONE = 2'h1;
  localparam logic [1:0] OPT_LOW = 2'h2;
  localparam logic [1:0] OPT_HIGH = 2'h3;
  localparam logic [1:0] ILIM_NORMAL = 2'h0;
  localparam logic [1:0] ILIM_LOW = 2'h1;
  localparam logic [1:0] ILIM_HIGH = 2'h2;
  localparam int CMP_N = 14;
  localparam int C_ENTRY_LO = 0;
  localparam int C_ENTRY_HI = 1;
  localparam int C_BURST_ON = 2;
  localparam int C_EXIT = 3;
  localparam int C_OLP = 4;
  localparam int C_LINE_OVERVOLTAGE_GUARD = 5;
  localparam int C_ERR_BIAS = 6;
  localparam int C_SEL_BIAS1 = 7;
  localparam int C_SEL_BIAS2 = 8;
  localparam int C_VCC_SEL = 9;
  localparam int C_VCC_ON = 10;
  localparam int C_VCC_OVP = 11;
  localparam int C_CS_SHORT = 12;
  localparam int C_OTP = 13;
  typedef enum logic [5:0] {
    ST_PRECHG    = 6'h01,
    ST_SELECT    = 6'h02,
    ST_NORMAL    = 6'h04,
    ST_BURST_ON  = 6'h08,
    ST_BURST_OFF = 6'h10,
    ST_PROTECT   = 6'h20
  } bmpc_state_e;
endpackage

/* File: design/bmpc_cmp_if.sv */
// Synchronised comparator levels passed from the synchroniser to the controller
`timescale 1ns/1ns
interface bmpc_cmp_if #(
  parameter int N = 14
);
  logic [N-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

/* File: design/bmpc_sync.sv */
// Two-flop synchronisers for the analog comparator outputs
`timescale 1ns/1ns
module bmpc_sync #(
  parameter int N = 14
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [N-1:0] rawIn,
  bmpc_cmp_if.src           outIf
);
  initial begin
    if (N < 1) begin
      $error("bmpc_sync needs at least one input");
    end
  end

  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= rawIn[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign outIf.level = sync_ff;
endmodule

/* File: design/bmpc_blank_timer.sv */
// Blanking timer that restarts whenever its qualifying condition drops
`timescale 1ns/1ns
module bmpc_blank_timer #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  initial begin
    if (W < 2) begin
      $error("bmpc_blank_timer width too small");
    end
  end

  logic [W-1:0] cnt_ff;
  logic         done_ff;
  wire  logic   atLimit = (cnt_ff >= limit);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!cond) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!atLimit) begin
      cnt_ff  <= cnt_ff + W'(1);
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b1;
    end
  end

  assign done = done_ff;
endmodule

/* File: design/bmpc_burst_ctrl.sv */
// Burst-mode supervisor, start-up option and isolation latch, line over-voltage gating
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module bmpc_burst_ctrl #(
  parameter int          CMP_W       = bmpc_pkg::CMP_N,
  parameter logic [15:0] RESTART_CYC = bmpc_pkg::RESTART_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [CMP_W-1:0]            cmpRaw,
  input  wire logic [bmpc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  output logic                             switchEnable,
  output logic                             biasEnable,
  output logic                             burstActive,
  output logic      [1:0]                  currentLimitSel,
  output logic                             oscTick,
  output logic                             selCurrentEnable,
  output logic                             pullupDisconnectSwitch,
  output logic                             errBiasEnable,
  output logic                             errAmpConnect,
  output logic                             softStartReq,
  output logic                             oddSkipMode,
  output logic                             olpDetEnable,
  output logic                             vccOvpDetEnable,
  output logic                             csShortDetEnable
);
  initial begin
    if (CMP_W != bmpc_pkg::CMP_N) begin
      $error("bmpc_burst_ctrl comparator width must match the index map");
    end
    if (RESTART_CYC < 16'h0002) begin
      $error("bmpc_burst_ctrl restart period too short");
    end
  end

  // Comparator synchronisation
  bmpc_cmp_if #(.N(CMP_W)) cmpIf ();

  bmpc_sync #(.N(CMP_W)) uSync (
    .mclk  (mclk),
    .rst   (rst),
    .rawIn (cmpRaw),
    .outIf (cmpIf.src)
  );

  wire logic fbEntryLo = cmpIf.level[bmpc_pkg::C_ENTRY_LO];
  wire logic fbEntryHi = cmpIf.level[bmpc_pkg::C_ENTRY_HI];
  wire logic fbBurstOn = cmpIf.level[bmpc_pkg::C_BURST_ON];
  wire logic fbExit    = cmpIf.level[bmpc_pkg::C_EXIT];
  wire logic fbOlp     = cmpIf.level[bmpc_pkg::C_OLP];
  wire logic lineOv    = cmpIf.level[bmpc_pkg::C_LINE_OVERVOLTAGE_GUARD];
  wire logic errBias   = cmpIf.level[bmpc_pkg::C_ERR_BIAS];
  wire logic selBias1  = cmpIf.level[bmpc_pkg::C_SEL_BIAS1];
  wire logic selBias2  = cmpIf.level[bmpc_pkg::C_SEL_BIAS2];
  wire logic vccSel    = cmpIf.level[bmpc_pkg::C_VCC_SEL];
  wire logic vccOn     = cmpIf.level[bmpc_pkg::C_VCC_ON];
  wire logic vccOvp    = cmpIf.level[bmpc_pkg::C_VCC_OVP];
  wire logic csShort   = cmpIf.level[bmpc_pkg::C_CS_SHORT];
  wire logic overTemp  = cmpIf.level[bmpc_pkg::C_OTP];

  // State and latched configuration
  bmpc_pkg::bmpc_state_e state_ff;
  bmpc_pkg::bmpc_state_e nxt_state;
  logic [1:0]            option_ff;
  logic                  nonIso_ff;
  logic                  oddSkip_ff;
  logic                  lineFault_ff;
  logic                  variant_ff;
  logic [15:0]           restartCnt_ff;
  logic [bmpc_pkg::OSC_W-1:0] oscCnt_ff;

  wire logic stPrechg   = (state_ff == bmpc_pkg::ST_PRECHG);
  wire logic stSelect   = (state_ff == bmpc_pkg::ST_SELECT);
  wire logic stNormal   = (state_ff == bmpc_pkg::ST_NORMAL);
  wire logic stBurstOn  = (state_ff == bmpc_pkg::ST_BURST_ON);
  wire logic stBurstOff = (state_ff == bmpc_pkg::ST_BURST_OFF);
  wire logic stProtect  = (state_ff == bmpc_pkg::ST_PROTECT);
  wire logic inBurst    = stBurstOn | stBurstOff;

  // Option chosen from the feedback voltage band at turn-on
  wire logic [1:0] sampledOpt = selBias2 ? bmpc_pkg::OPT_HIGH :
                                selBias1 ? bmpc_pkg::OPT_LOW :
                                bmpc_pkg::OPT_NONE;

  // Entry comparator follows the latched option
  wire logic burstAllowed = (option_ff != bmpc_pkg::OPT_NONE);
  wire logic fbBelowEntry = (option_ff == bmpc_pkg::OPT_LOW) ? fbEntryLo : fbEntryHi;

  // Blanking timers
  wire logic entryCond = stNormal & burstAllowed & fbBelowEntry & ~fbExit;
  wire logic olpCond   = stNormal & fbOlp;
  logic      entryDone;
  logic      olpDone;

  bmpc_blank_timer #(.W(bmpc_pkg::BLANK_W)) uEntryBlank (
    .mclk  (mclk),
    .rst   (rst),
    .cond  (entryCond),
    .limit (bmpc_pkg::ENTRY_BLANK_CYC),
    .done  (entryDone)
  );

  bmpc_blank_timer #(.W(bmpc_pkg::BLANK_W)) uOlpBlank (
    .mclk  (mclk),
    .rst   (rst),
    .cond  (olpCond),
    .limit (bmpc_pkg::OLP_BLANK_CYC),
    .done  (olpDone)
  );

  // Fault qualification per operating mode
  wire logic ovpArmed   = ~stBurstOff;
  wire logic faultAny   = lineOv | overTemp | (ovpArmed & (vccOvp | csShort));
  wire logic olpTrip    = stNormal & olpDone;
  wire logic restartEnd = stProtect & (restartCnt_ff >= RESTART_CYC);
  wire logic faultClear = ~lineOv & ~overTemp & ~vccOvp & ~csShort;
  wire logic leaveProt  = restartEnd & faultClear;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bmpc_pkg::ST_PRECHG: begin
        if (vccSel) begin
          nxt_state = bmpc_pkg::ST_SELECT;
        end
      end
      bmpc_pkg::ST_SELECT: begin
        if (vccOn) begin
          nxt_state = bmpc_pkg::ST_NORMAL;
        end
      end
      bmpc_pkg::ST_NORMAL: begin
        if (faultAny || olpTrip) begin
          nxt_state = bmpc_pkg::ST_PROTECT;
        end else if (entryDone) begin
          nxt_state = bmpc_pkg::ST_BURST_OFF;
        end
      end
      bmpc_pkg::ST_BURST_ON: begin
        if (faultAny) begin
          nxt_state = bmpc_pkg::ST_PROTECT;
        end else if (fbExit) begin
          nxt_state = bmpc_pkg::ST_NORMAL;
        end else if (!fbBurstOn) begin
          nxt_state = bmpc_pkg::ST_BURST_OFF;
        end
      end
      bmpc_pkg::ST_BURST_OFF: begin
        if (faultAny) begin
          nxt_state = bmpc_pkg::ST_PROTECT;
        end else if (fbExit) begin
          nxt_state = bmpc_pkg::ST_NORMAL;
        end else if (fbBurstOn) begin
          nxt_state = bmpc_pkg::ST_BURST_ON;
        end
      end
      bmpc_pkg::ST_PROTECT: begin
        if (leaveProt) begin
          nxt_state = bmpc_pkg::ST_NORMAL;
        end
      end
      default: begin
        nxt_state = bmpc_pkg::ST_PRECHG;
      end
    endcase
  end

  wire logic enterProt = (nxt_state == bmpc_pkg::ST_PROTECT) & ~stProtect;
  wire logic startSoft = (nxt_state == bmpc_pkg::ST_NORMAL) & (stSelect | stProtect);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= bmpc_pkg::ST_PRECHG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Start-up latches for option and feedback configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      option_ff <= bmpc_pkg::OPT_HIGH;
      nonIso_ff <= 1'b0;
    end else if (stSelect && vccOn) begin
      option_ff <= sampledOpt;
      nonIso_ff <= errBias;
    end
  end

  // Protection bookkeeping and restart timer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oddSkip_ff    <= 1'b0;
      lineFault_ff  <= 1'b0;
      restartCnt_ff <= 16'h0000;
    end else if (enterProt) begin
      oddSkip_ff    <= olpTrip & ~faultAny;
      lineFault_ff  <= lineOv;
      restartCnt_ff <= 16'h0000;
    end else if (restartEnd) begin
      lineFault_ff  <= lineOv;
      restartCnt_ff <= 16'h0000;
    end else if (stProtect) begin
      restartCnt_ff <= restartCnt_ff + 16'h0001;
    end else begin
      oddSkip_ff    <= 1'b0;
      lineFault_ff  <= 1'b0;
    end
  end

  // Switching oscillator tick, burst rate in burst states
  wire logic [bmpc_pkg::OSC_W-1:0] normCyc  = variant_ff ? bmpc_pkg::NORM_HI_CYC :
                                              bmpc_pkg::NORM_LO_CYC;
  wire logic [bmpc_pkg::OSC_W-1:0] burstCyc = variant_ff ? bmpc_pkg::BURST_HI_CYC :
                                              bmpc_pkg::BURST_LO_CYC;
  wire logic [bmpc_pkg::OSC_W-1:0] periodCyc = inBurst ? burstCyc : normCyc;
  wire logic oscWrap = (oscCnt_ff >= periodCyc - bmpc_pkg::OSC_W'(1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscCnt_ff <= '0;
    end else if (oscWrap) begin
      oscCnt_ff <= '0;
    end else begin
      oscCnt_ff <= oscCnt_ff + bmpc_pkg::OSC_W'(1);
    end
  end

  // Output decode
  wire logic       switchNext = stNormal | stBurstOn;
  wire logic       biasNext   = ~stBurstOff;
  wire logic [1:0] burstIlim  = (option_ff == bmpc_pkg::OPT_LOW) ? bmpc_pkg::ILIM_LOW :
                                bmpc_pkg::ILIM_HIGH;
  wire logic [1:0] ilimNext   = inBurst ? burstIlim : bmpc_pkg::ILIM_NORMAL;
  wire logic       selNext    = stSelect;
  wire logic       errConNext = nonIso_ff & ~stPrechg & ~stSelect;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      switchEnable           <= 1'b0;
      biasEnable             <= 1'b1;
      burstActive            <= 1'b0;
      currentLimitSel        <= bmpc_pkg::ILIM_NORMAL;
      oscTick                <= 1'b0;
      selCurrentEnable       <= 1'b0;
      pullupDisconnectSwitch <= 1'b0;
      errBiasEnable          <= 1'b0;
      errAmpConnect          <= 1'b0;
      softStartReq           <= 1'b0;
      oddSkipMode            <= 1'b0;
      olpDetEnable           <= 1'b0;
      vccOvpDetEnable        <= 1'b0;
      csShortDetEnable       <= 1'b0;
    end else begin
      switchEnable           <= switchNext & oscWrap;
      biasEnable             <= biasNext;
      burstActive            <= inBurst;
      currentLimitSel        <= ilimNext;
      oscTick                <= oscWrap;
      selCurrentEnable       <= selNext;
      pullupDisconnectSwitch <= selNext;
      errBiasEnable          <= stPrechg | stSelect;
      errAmpConnect          <= errConNext;
      softStartReq           <= startSoft;
      oddSkipMode            <= oddSkip_ff;
      olpDetEnable           <= stNormal;
      vccOvpDetEnable        <= ovpArmed & ~stPrechg & ~stSelect;
      csShortDetEnable       <= ovpArmed & ~stPrechg & ~stSelect;
    end
  end

  // Register port
  wire logic selStatus = (regAddr == bmpc_pkg::REG_STATUS);
  wire logic selCtrl   = (regAddr == bmpc_pkg::REG_CTRL);
  logic [31:0] statusWord;
  logic [31:0] rdWord;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[bmpc_pkg::STAT_STATE_LSB +: 6] = state_ff;
    statusWord[bmpc_pkg::STAT_OPT_LSB +: 2]   = option_ff;
    statusWord[bmpc_pkg::STAT_NONISO_BIT]     = nonIso_ff;
    statusWord[bmpc_pkg::STAT_ODD_BIT]        = oddSkip_ff;
    statusWord[bmpc_pkg::STAT_LINE_OVERVOLTAGE_GUARD_BIT]       = lineFault_ff;
  end

  always_comb begin
    rdWord = 32'h0000_0000;
    if (selStatus) begin
      rdWord = statusWord;
    end else if (selCtrl) begin
      rdWord[bmpc_pkg::CTRL_VARIANT_BIT] = variant_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      variant_ff <= bmpc_pkg::CTRL_VARIANT_RST;
    end else if (regWr && selCtrl) begin
      variant_ff <= regWdata[bmpc_pkg::CTRL_VARIANT_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdWord;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule

/* File: test/bmpc_analog_model.sv */
// Behavioural comparator front end driven by pin voltages in millivolts
`timescale 1ns/1ns
module bmpc_analog_model #(
  parameter int BURST_ON_MV = 1250,
  parameter int EXIT_MV     = 2500,
  parameter int OLP_MV      = 2800,
  parameter int BIAS1_MV    = 1000,
  parameter int BIAS2_MV    = 2000,
  parameter int VCC_ON_MV   = 16000,
  parameter int VCC_OVP_MV  = 25500
) (
  input  int          fbMv,
  input  int          vccMv,
  input  int          lineMv,
  input  int          errMv,
  input  logic        csShort,
  input  logic        otp,
  output logic [13:0] cmpRaw
);
  assign cmpRaw[0] = fbMv < 930;
  assign cmpRaw[1] = fbMv < 1030;
  assign cmpRaw[2] = fbMv > BURST_ON_MV;
  assign cmpRaw[3] = fbMv > EXIT_MV;
  assign cmpRaw[4] = fbMv > OLP_MV;
  assign cmpRaw[5] = lineMv > 2850;
  assign cmpRaw[6] = errMv > 200;
  assign cmpRaw[7] = fbMv > BIAS1_MV;
  assign cmpRaw[8] = fbMv > BIAS2_MV;
  assign cmpRaw[9] = vccMv > 4440;
  assign cmpRaw[10] = vccMv > VCC_ON_MV;
  assign cmpRaw[11] = vccMv > VCC_OVP_MV;
  assign cmpRaw[12] = csShort;
  assign cmpRaw[13] = otp;
endmodule

/* File: test/bmpc_checker.sv */
// Port-level assertions for the burst-mode protection controller
`timescale 1ns/1ns
module bmpc_checker #(
  parameter int CMP_W = 14
) (
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic [CMP_W-1:0] cmpRaw,
  input wire logic             regRd,
  input wire logic [31:0]      regRdata,
  input wire logic             switchEnable,
  input wire logic             biasEnable,
  input wire logic             burstActive,
  input wire logic [1:0]       currentLimitSel,
  input wire logic             selCurrentEnable,
  input wire logic             pullupDisconnectSwitch,
  input wire logic             errBiasEnable,
  input wire logic             softStartReq,
  input wire logic             oddSkipMode,
  input wire logic             olpDetEnable,
  input wire logic             vccOvpDetEnable,
  input wire logic             csShortDetEnable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_line_overvoltage_guard_stop;
    cmpRaw[bmpc_pkg::C_LINE_OVERVOLTAGE_GUARD] [*5] |-> !switchEnable;
  endproperty
  a_line_overvoltage_guard_stop: assert property (p_line_overvoltage_guard_stop) else $error("switching in line fault");
  property p_exit;
    cmpRaw[bmpc_pkg::C_EXIT] [*5] |-> !burstActive;
  endproperty
  a_exit: assert property (p_exit) else $error("burst held above exit level");
  property p_ilim;
    burstActive |-> currentLimitSel != bmpc_pkg::ILIM_NORMAL;
  endproperty
  a_ilim: assert property (p_ilim) else $error("normal limit in burst");
  property p_ilim_norm;
    !burstActive |-> currentLimitSel == bmpc_pkg::ILIM_NORMAL;
  endproperty
  a_ilim_norm: assert property (p_ilim_norm) else $error("burst limit outside burst");
  property p_paused;
    !biasEnable |-> burstActive && !switchEnable;
  endproperty
  a_paused: assert property (p_paused) else $error("bias off outside burst pause");
  property p_det;
    !biasEnable |-> !vccOvpDetEnable && !csShortDetEnable;
  endproperty
  a_det: assert property (p_det) else $error("detector armed in burst pause");
  property p_olp;
    olpDetEnable |-> !burstActive && biasEnable;
  endproperty
  a_olp: assert property (p_olp) else $error("overload detect outside normal");
  property p_sel;
    (selCurrentEnable == pullupDisconnectSwitch) && (!selCurrentEnable || errBiasEnable);
  endproperty
  a_sel: assert property (p_sel) else $error("selection outputs disagree");
  property p_ss;
    softStartReq |=> olpDetEnable && !softStartReq;
  endproperty
  a_ss: assert property (p_ss) else $error("soft start pulse wrong");
  property p_rd;
    regRdata != 32'h0000_0000 |-> $past(regRd);
  endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
  property p_odd;
    $rose(oddSkipMode) |-> !switchEnable && !burstActive;
  endproperty
  a_odd: assert property (p_odd) else $error("odd skip while switching");
  c_burst: cover property ($rose(burstActive));
  c_burst_on: cover property (burstActive && switchEnable);
  c_odd: cover property ($rose(oddSkipMode));
  c_ss: cover property (softStartReq);
endmodule
bind bmpc_burst_ctrl bmpc_checker #(.CMP_W(CMP_W)) u_chk (
  .mclk(mclk), .rst(rst), .cmpRaw(cmpRaw), .regRd(regRd), .regRdata(regRdata),
  .switchEnable(switchEnable), .biasEnable(biasEnable), .burstActive(burstActive),
  .currentLimitSel(currentLimitSel), .selCurrentEnable(selCurrentEnable),
  .pullupDisconnectSwitch(pullupDisconnectSwitch), .errBiasEnable(errBiasEnable),
  .softStartReq(softStartReq), .oddSkipMode(oddSkipMode), .olpDetEnable(olpDetEnable),
  .vccOvpDetEnable(vccOvpDetEnable), .csShortDetEnable(csShortDetEnable));

/* File: test/tb_top.sv */
// Self-checking bench for the burst-mode protection controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic        mclk = 1'b0;
  logic        rst, regWr, regRd, csShort, otp;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, s;
  logic [13:0] cmpRaw;
  logic [1:0]  currentLimitSel;
  logic        switchEnable, biasEnable, burstActive, oscTick, selCurrentEnable;
  logic        pullupDisconnectSwitch, errBiasEnable, errAmpConnect, softStartReq;
  logic        oddSkipMode, olpDetEnable, vccOvpDetEnable, csShortDetEnable;
  int          fbMv, vccMv, lineMv, errMv, n, k, nMismatch, checked;
  always #25 mclk = ~mclk;
  bmpc_analog_model u_ana (.fbMv(fbMv), .vccMv(vccMv), .lineMv(lineMv), .errMv(errMv),
    .csShort(csShort), .otp(otp), .cmpRaw(cmpRaw));
  bmpc_burst_ctrl #(.RESTART_CYC(16'h0014)) dut (.mclk(mclk), .rst(rst), .cmpRaw(cmpRaw),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .switchEnable(switchEnable), .biasEnable(biasEnable),
    .burstActive(burstActive), .currentLimitSel(currentLimitSel), .oscTick(oscTick),
    .selCurrentEnable(selCurrentEnable), .pullupDisconnectSwitch(pullupDisconnectSwitch),
    .errBiasEnable(errBiasEnable), .errAmpConnect(errAmpConnect),
    .softStartReq(softStartReq), .oddSkipMode(oddSkipMode), .olpDetEnable(olpDetEnable),
    .vccOvpDetEnable(vccOvpDetEnable), .csShortDetEnable(csShortDetEnable));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic wait_st(input logic [5:0] st, input int lim);
    logic [31:0] v;
    int i;
    i = 0;
    rd(bmpc_pkg::REG_STATUS, v);
    while (v[5:0] !== st && i < lim) begin
      rd(bmpc_pkg::REG_STATUS, v);
      i++;
    end
    `CHK("state", st, v[5:0])
    if (v[5:0] !== st) close_out();
  endtask
  task automatic period(output int p);
    int i;
    i = 0;
    p = 0;
    do begin @(posedge mclk); #1; i++; end while (oscTick !== 1'b1 && i < 1000);
    do begin @(posedge mclk); #1; p++; end while (oscTick !== 1'b1 && p < 1000);
    if (i == 1000 || p == 1000) begin
      `CHK("tick", 1'b1, oscTick)
      close_out();
    end
  endtask
  task automatic startup(input int fb, input int err, input logic [1:0] opt, input logic ni);
    rst <= 1'b1;
    vccMv <= 3000;
    lineMv <= 0;
    fbMv <= fb;
    errMv <= err;
    cyc(3);
    rst <= 1'b0;
    rd(bmpc_pkg::REG_STATUS, s);
    `CHK("rstStat", 9'h0C1, {s[10:8], s[5:0]})
    `CHK("errBias", 1'b1, errBiasEnable)
    `CHK("selOff", 1'b0, selCurrentEnable)
    vccMv <= 5000;
    wait_st(6'h02, 20);
    `CHK("pullOpen", 1'b1, pullupDisconnectSwitch)
    vccMv <= 18000;
    wait_st(6'h04, 20);
    fbMv <= 1500;
    rd(bmpc_pkg::REG_STATUS, s);
    `CHK("opt", {ni, opt}, s[10:8])
    `CHK("ampConn", ni, errAmpConnect)
    `CHK("selDone", 2'h0, {selCurrentEnable, pullupDisconnectSwitch})
  endtask
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0000_0000;
    csShort = 1'b0;
    otp = 1'b0;
    nMismatch = 0;
    checked = 0;
    startup(2500, 300, 2'h3, 1'b1);
    fbMv <= 1000;
    cyc(300);
    fbMv <= 1500;
    cyc(10);
    fbMv <= 1000;
    cyc(350);
    wait_st(6'h04, 0);
    wait_st(6'h10, 60);
    `CHK("ilimHi", bmpc_pkg::ILIM_HIGH, currentLimitSel)
    `CHK("biasOff", 1'b0, biasEnable)
    `CHK("detOff", 2'h0, {vccOvpDetEnable, csShortDetEnable})
    csShort <= 1'b1;
    cyc(20);
    wait_st(6'h10, 0);
    csShort <= 1'b0;
    fbMv <= 1300;
    wait_st(6'h08, 20);
    `CHK("biasOn", 1'b1, biasEnable)
    period(n);
    `CHK("burstLo", bmpc_pkg::CLK_HZ / 83000, n)
    wr(bmpc_pkg::REG_CTRL, 32'h0000_0001);
    rd(bmpc_pkg::REG_CTRL, s);
    `CHK("variant", 32'h0000_0001, s)
    period(n);
    period(n);
    `CHK("burstHi", bmpc_pkg::CLK_HZ / 103000, n)
    fbMv <= 1000;
    wait_st(6'h10, 20);
    fbMv <= 2600;
    wait_st(6'h04, 20);
    `CHK("ilimN", bmpc_pkg::ILIM_NORMAL, currentLimitSel)
    fbMv <= 1500;
    period(n);
    `CHK("normHi", bmpc_pkg::CLK_HZ / 125000, n)
    lineMv <= 3000;
    wait_st(6'h20, 20);
    k = 0;
    repeat (100) begin
      @(posedge mclk);
      #1;
      if (switchEnable !== 1'b0) k++;
    end
    `CHK("noSwitch", 0, k)
    wait_st(6'h20, 0);
    lineMv <= 0;
    wait_st(6'h04, 30);
    fbMv <= 2900;
    cyc(550);
    wait_st(6'h04, 0);
    wait_st(6'h20, 60);
    cyc(2);
    #1;
    `CHK("oddSkip", 1'b1, oddSkipMode)
    fbMv <= 1500;
    wait_st(6'h04, 30);
    startup(500, 0, 2'h1, 1'b0);
    fbMv <= 500;
    cyc(500);
    wait_st(6'h04, 0);
    startup(1500, 0, 2'h2, 1'b0);
    fbMv <= 1000;
    cyc(500);
    wait_st(6'h04, 0);
    fbMv <= 900;
    wait_st(6'h10, 250);
    `CHK("ilimLo", bmpc_pkg::ILIM_LOW, currentLimitSel)
    fbMv <= 1300;
    wait_st(6'h08, 20);
    csShort <= 1'b1;
    wait_st(6'h20, 20);
    csShort <= 1'b0;
    otp <= 1'b1;
    cyc(60);
    wait_st(6'h20, 0);
    otp <= 1'b0;
    fbMv <= 1500;
    wait_st(6'h04, 30);
    close_out();
  end
endmodule
